// [ipfs_sequencer.sv]
// Inverter phase firing sequencer: step logic, start-stop, firing, fault
//
// Overview of operation
// RULE_01 - Six pulses per cycle become three-phase full-wave logic in ABC order.
// RULE_02 - Each commutation command is steered to the phase of the current step.
// RULE_03 - Each phase starts and stops on its own, at its designated step.
// RULE_04 - Starting fires the supply SCR before any inverter SCR of that phase.
// RULE_05 - Stopping ends on the lower SCR, leaving the capacitor in start polarity.
// RULE_06 - Separate outputs: six inverter, six commutation, three supply SCRs.
// RULE_07 - In 460 volt mode each supply output drives a series SCR pair.
// RULE_08 - Inverter firing lasts half a cycle, gated by the firing oscillator.
// RULE_09 - Commutation and supply outputs give one short pulse per event.
// RULE_10 - Fault shutdown blocks all normal inverter firing at once.
// RULE_11 - During fault all six inverter SCRs fire together for shoot-through.
// RULE_12 - Upstream stops outgoing SCR, fires commutation, then supply and oncoming.
// RULE_13 - Upstream gives one commutation pulse per commutation, six per cycle.
// RULE_14 - Upstream asserts fault on short circuit, undervoltage or overvoltage.
// RULE_15 - Reset clears all firing, sets the initial step and stops all phases.
// RULE_16 - Six-state position advances one step per pulse and wraps after six.
`timescale 1ns/10ps
`include "ipfs_defines.svh"

module ipfs_sequencer #(
  parameter int PULSE_CYCLES = `IPFS_PULSE_CYCLES
) (
  // Clock and reset
  input  wire logic                         clk_in,
  input  wire logic                         reset_in,
  // Commutation logic from upstream control
  input  wire logic                         comm_pulse_in,
  input  wire logic                         comm_fire_in,
  input  wire logic                         oncoming_fire_in,
  input  wire logic                         fire_osc_in,
  input  wire logic                         fault_in,
  // Per-phase run requests and voltage strap
  input  wire logic [`IPFS_PHASES-1:0]      phase_run_in,
  input  wire logic                         mode_460_in,
  // Firing outputs to the pulse transformer drivers
  output logic      [`IPFS_INV_SCRS-1:0]    inv_fire_out,
  output logic      [`IPFS_COMM_SCRS-1:0]   comm_fire_out,
  output logic      [`IPFS_PSU_SCRS-1:0]    psu_fire_out,
  output logic      [`IPFS_PSU_SCRS-1:0]    psu_pair_fire_out,
  // Status
  output ipfs_pkg::ipfs_step_type           step_out,
  output logic      [`IPFS_PHASES-1:0]      phase_running_out,
  output logic                              fault_active_out
);

  import ipfs_pkg::*;

  // --------------------------------------------------------------------
  // State
  // --------------------------------------------------------------------

  // Whole state of the sequencer in one record
  typedef struct packed {
    ipfs_step_type                             step;
    logic [1:0]                                phase;
    logic                                      upper;
    ipfs_action_type                           action;
    logic                                      comm_done;
    ipfs_phase_state_type [`IPFS_PHASES-1:0]   ph_state;
    logic [`IPFS_INV_SCRS-1:0]                 conduct;
    logic [`IPFS_INV_SCRS-1:0]                 inv_fire;
    logic [`IPFS_PULSE_CH-1:0]                 trig;
    logic [`IPFS_PHASES-1:0]                   running;
    logic                                      fault;
    logic                                      mode_460;
  } ipfs_seq_state_type;

  // Registered state and the value it takes at the next edge
  ipfs_seq_state_type state;
  ipfs_seq_state_type next_state;

  // Generator outputs: commutation, supply, series partner
  logic [`IPFS_PULSE_CH-1:0] pulses;

  // --------------------------------------------------------------------
  // Step decoding
  // --------------------------------------------------------------------

  // Phase switched at each step: A+, C-, B+, A-, C+, B-
  // Each phase shows once upper and once lower per cycle
  function automatic logic [1:0] ipfs_phase_of(input ipfs_step_type st);
    logic [1:0] ph;
    ph = `IPFS_PH_A;
    case (st)
      IPFS_STEP_0: ph = `IPFS_PH_A;
      IPFS_STEP_1: ph = `IPFS_PH_C;
      IPFS_STEP_2: ph = `IPFS_PH_B;
      IPFS_STEP_3: ph = `IPFS_PH_A;
      IPFS_STEP_4: ph = `IPFS_PH_C;
      IPFS_STEP_5: ph = `IPFS_PH_B;
      default:     ph = `IPFS_PH_A;
    endcase
    return ph;
  endfunction

  // Even steps bring an upper SCR on, odd steps a lower one
  // Outgoing device is the other switch of the same phase
  function automatic logic ipfs_upper_of(input ipfs_step_type st);
    logic up;
    up = 1'b0;
    case (st)
      IPFS_STEP_0,
      IPFS_STEP_2,
      IPFS_STEP_4: up = 1'b1;
      default:     up = 1'b0;
    endcase
    return up;
  endfunction

  // One step forward, wrapping after the sixth
  function automatic ipfs_step_type ipfs_advance(input ipfs_step_type st);
    ipfs_step_type nx;
    nx = IPFS_STEP_0;
    case (st)
      IPFS_STEP_0: nx = IPFS_STEP_1;
      IPFS_STEP_1: nx = IPFS_STEP_2;
      IPFS_STEP_2: nx = IPFS_STEP_3;
      IPFS_STEP_3: nx = IPFS_STEP_4;
      IPFS_STEP_4: nx = IPFS_STEP_5;
      IPFS_STEP_5: nx = IPFS_STEP_0;
      default:     nx = IPFS_STEP_0;
    endcase
    return nx;
  endfunction

  // --------------------------------------------------------------------
  // Next-state logic
  // --------------------------------------------------------------------

  // SCR index: upper = 2*phase, lower = 2*phase+1
  always_comb begin
    logic [2:0] out_idx;
    logic [2:0] in_idx;
    next_state      = state;
    next_state.trig = '0;
    out_idx         = {state.phase, state.upper};
    in_idx          = {state.phase, ~state.upper};

    // Position tracks the reference even during a fault
    if (comm_pulse_in) begin
      next_state.step      = ipfs_advance(state.step);            // see RULE_16
      next_state.phase     = ipfs_phase_of(next_state.step);      // see RULE_01
      next_state.upper     = ipfs_upper_of(next_state.step);
      next_state.comm_done = 1'b0;
    end

    // Fault outranks every command, so no late oncoming firing
    // can meet a half-discharged capacitor
    if (fault_in) begin
      // Forget all conduction so a later restart begins from charging
      next_state.conduct = '0;                                    // see RULE_10
      next_state.action  = IPFS_ACT_NONE;
      for (int i = 0; i < `IPFS_PHASES; i++) begin
        next_state.ph_state[i] = IPFS_PH_STOPPED;
      end
    end else if (comm_pulse_in) begin
      // Decide what this interval does to the steered phase
      next_state.action = IPFS_ACT_NONE;
      case (state.ph_state[next_state.phase])
        IPFS_PH_RUNNING: begin
          // Outgoing SCR stops at the start of the interval
          next_state.conduct[{next_state.phase, next_state.upper}] = 1'b0;  // see RULE_02
          if (next_state.upper && !phase_run_in[next_state.phase]) begin
            // Stop only where the lower SCR was the last one fired
            next_state.action = IPFS_ACT_STOP;                    // see RULE_05
            next_state.ph_state[next_state.phase] = IPFS_PH_STOPPED;  // see RULE_03
          end else begin
            next_state.action = IPFS_ACT_NORMAL;
          end
        end
        IPFS_PH_STOPPED: begin
          // Start only at the step that brings the upper SCR on
          if (next_state.upper && phase_run_in[next_state.phase]) begin
            next_state.action = IPFS_ACT_START;                   // see RULE_03
            next_state.ph_state[next_state.phase] = IPFS_PH_CHARGING;
          end
        end
        IPFS_PH_CHARGING: begin
          // Charging interval passed without a supply firing: give up
          next_state.ph_state[next_state.phase] = IPFS_PH_STOPPED;
        end
        default: begin
          next_state.ph_state[next_state.phase] = IPFS_PH_STOPPED;
        end
      endcase
    end else begin
      // Fire inputs in the cycle of a commutation pulse are dropped,
      // never steered to the phase being left
      // Commutation SCR of the outgoing device, once per interval
      if (comm_fire_in && !state.comm_done &&
          (state.action == IPFS_ACT_NORMAL || state.action == IPFS_ACT_STOP)) begin
        next_state.trig[`IPFS_COMM_BASE + out_idx] = 1'b1;       // see RULE_02
        next_state.comm_done = 1'b1;
        if (state.action == IPFS_ACT_STOP) begin
          next_state.action = IPFS_ACT_NONE;                      // see RULE_05
        end
      end
      // Supply SCR and oncoming inverter SCR
      if (oncoming_fire_in) begin
        case (state.action)
          IPFS_ACT_NORMAL: begin
            // Supply tops up the capacitor as the oncoming device fires
            next_state.trig[`IPFS_PSU_BASE + state.phase] = 1'b1;
            next_state.trig[`IPFS_PAIR_BASE + state.phase] = state.mode_460;  // see RULE_07
            next_state.conduct[in_idx] = 1'b1;                    // see RULE_02
            next_state.action = IPFS_ACT_NONE;
          end
          IPFS_ACT_START: begin
            // Charge the capacitor only; inverter firing waits a turn
            next_state.trig[`IPFS_PSU_BASE + state.phase] = 1'b1;  // see RULE_04
            next_state.trig[`IPFS_PAIR_BASE + state.phase] = state.mode_460;
            next_state.ph_state[state.phase] = IPFS_PH_RUNNING;
            next_state.action = IPFS_ACT_NONE;
          end
          IPFS_ACT_NONE,
          IPFS_ACT_STOP: begin
            // Stopping phase gets no supply or oncoming firing
            next_state.action = state.action;
          end
          default: begin
            next_state.action = IPFS_ACT_NONE;
          end
        endcase
      end
    end

    // Inverter firing: held conduction chopped by the oscillator
    // Shoot-through is chopped too, sparing the pulse transformers
    if (fault_in) begin
      next_state.inv_fire = {`IPFS_INV_SCRS{fire_osc_in}};        // see RULE_11
    end else begin
      next_state.inv_fire = next_state.conduct & {`IPFS_INV_SCRS{fire_osc_in}};  // see RULE_08
    end
    next_state.fault = fault_in;

    // Running flags for status
    for (int i = 0; i < `IPFS_PHASES; i++) begin
      next_state.running[i] = (next_state.ph_state[i] == IPFS_PH_RUNNING);
    end

    // Reset; strap is captured while reset is held
    // Step 5 makes the first commutation pulse land on step 0
    // comm_done set, so a fire before the first pulse is ignored
    if (reset_in) begin
      next_state           = '0;                                  // see RULE_15
      next_state.step      = IPFS_STEP_5;
      next_state.upper     = 1'b0;
      next_state.phase     = ipfs_phase_of(IPFS_STEP_5);
      next_state.action    = IPFS_ACT_NONE;
      next_state.comm_done = 1'b1;
      next_state.mode_460  = mode_460_in;
      for (int i = 0; i < `IPFS_PHASES; i++) begin
        next_state.ph_state[i] = IPFS_PH_STOPPED;
      end
    end
  end

  // --------------------------------------------------------------------
  // State register
  // --------------------------------------------------------------------

  // Synchronous reset lives in the next-state logic
  // One register for all state keeps every output glitch free
  always_ff @(posedge clk_in) begin
    state <= next_state;
  end

  // --------------------------------------------------------------------
  // Short pulse generators
  // --------------------------------------------------------------------

  // Fixed width keeps pulse transformers out of saturation
  // Triggers are registered: pulses start one edge after the command edge
  ipfs_pulse_gen #(
    .CHANNELS     (`IPFS_PULSE_CH),
    .PULSE_CYCLES (PULSE_CYCLES),
    .CNT_W        (`IPFS_PULSE_CNT_W)
  ) u_pulse_gen (
    .clk_in    (clk_in),
    .reset_in  (reset_in),
    .trig_in   (state.trig),                                      // see RULE_09
    .pulse_out (pulses)
  );

  // --------------------------------------------------------------------
  // Outputs
  // --------------------------------------------------------------------

  // All straight from flip-flops
  // Pulse outputs come from the generator's own registers
  assign inv_fire_out      = state.inv_fire;                      // see RULE_06
  assign comm_fire_out     = pulses[`IPFS_COMM_BASE +: `IPFS_COMM_SCRS];
  assign psu_fire_out      = pulses[`IPFS_PSU_BASE +: `IPFS_PSU_SCRS];
  assign psu_pair_fire_out = pulses[`IPFS_PAIR_BASE +: `IPFS_PSU_SCRS];
  assign step_out          = state.step;
  assign phase_running_out = state.running;
  assign fault_active_out  = state.fault;

endmodule

// [ipfs_defines.svh]
// Constants for the inverter phase firing sequencer
`ifndef IPFS_DEFINES_SVH
`define IPFS_DEFINES_SVH

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define IPFS_CLK_PERIOD_NS   5
`define IPFS_PULSE_TIME_NS   10000
// Least time, so round up to whole cycles
`define IPFS_PULSE_CYCLES    ((`IPFS_PULSE_TIME_NS + `IPFS_CLK_PERIOD_NS - 1) / `IPFS_CLK_PERIOD_NS)
`define IPFS_PULSE_CNT_W     12

// ----------------------------------------------------------------------
// Counts and channel layout
// ----------------------------------------------------------------------
`define IPFS_PHASES          3
`define IPFS_INV_SCRS        6
`define IPFS_COMM_SCRS       6
`define IPFS_PSU_SCRS        3
`define IPFS_PULSE_CH        12
`define IPFS_COMM_BASE       0
`define IPFS_PSU_BASE        6
`define IPFS_PAIR_BASE       9

// ----------------------------------------------------------------------
// Phase indices
// ----------------------------------------------------------------------
`define IPFS_PH_A            2'h0
`define IPFS_PH_B            2'h1
`define IPFS_PH_C            2'h2

`endif

// [ipfs_pkg.sv]
// Types shared by the inverter phase firing sequencer files
package ipfs_pkg;

  // Six commutation steps, one-hot
  typedef enum logic [5:0] {
    IPFS_STEP_0 = 6'h01,
    IPFS_STEP_1 = 6'h02,
    IPFS_STEP_2 = 6'h04,
    IPFS_STEP_3 = 6'h08,
    IPFS_STEP_4 = 6'h10,
    IPFS_STEP_5 = 6'h20
  } ipfs_step_type;

  // Start-stop state of one phase
  typedef enum logic [2:0] {
    IPFS_PH_STOPPED  = 3'h1,
    IPFS_PH_CHARGING = 3'h2,
    IPFS_PH_RUNNING  = 3'h4
  } ipfs_phase_state_type;

  // What the current commutation interval does to its phase
  typedef enum logic [3:0] {
    IPFS_ACT_NONE   = 4'h1,
    IPFS_ACT_NORMAL = 4'h2,
    IPFS_ACT_START  = 4'h4,
    IPFS_ACT_STOP   = 4'h8
  } ipfs_action_type;

endpackage

// [ipfs_pulse_gen.sv]
// Fixed-width single short pulse generators, one per channel
`timescale 1ns/10ps
`include "ipfs_defines.svh"

module ipfs_pulse_gen #(
  parameter int CHANNELS     = `IPFS_PULSE_CH,
  parameter int PULSE_CYCLES = `IPFS_PULSE_CYCLES,
  parameter int CNT_W        = `IPFS_PULSE_CNT_W
) (
  // Clock and reset
  input  wire logic                clk_in,
  input  wire logic                reset_in,
  // One-cycle triggers
  input  wire logic [CHANNELS-1:0] trig_in,
  // Pulses
  output logic      [CHANNELS-1:0] pulse_out
);

  // --------------------------------------------------------------------
  // State
  // --------------------------------------------------------------------
  typedef struct packed {
    logic [CHANNELS-1:0][CNT_W-1:0] count;
    logic [CHANNELS-1:0]            pulse;
  } ipfs_pulse_state_type;

  localparam logic [CNT_W-1:0] LAST = CNT_W'(PULSE_CYCLES - 1);

  ipfs_pulse_state_type state;
  ipfs_pulse_state_type next_state;

  // Retrigger while active is ignored, so each event gives one pulse
  always_comb begin
    next_state = state;
    for (int i = 0; i < CHANNELS; i++) begin
      if (state.pulse[i]) begin
        if (state.count[i] == LAST) begin
          next_state.pulse[i] = 1'b0;
          next_state.count[i] = '0;
        end else begin
          next_state.count[i] = state.count[i] + CNT_W'(1);
        end
      end else if (trig_in[i]) begin
        next_state.pulse[i] = 1'b1;
        next_state.count[i] = '0;
      end
    end
    if (reset_in) begin
      next_state = '0;
    end
  end

  // State register
  always_ff @(posedge clk_in) begin
    state <= next_state;
  end

  assign pulse_out = state.pulse;

endmodule

// [ipfs_sequencer_chk.sv]
// Port-level assertions for the sequencer, bound to every instance
`timescale 1ns/10ps
`include "ipfs_defines.svh"

module ipfs_sequencer_chk #(
  parameter int PULSE_CYCLES = `IPFS_PULSE_CYCLES
) (
  // Clock and reset
  input wire logic                        clk_in,
  input wire logic                        reset_in,
  // Upstream commands
  input wire logic                        comm_pulse_in,
  input wire logic                        comm_fire_in,
  input wire logic                        oncoming_fire_in,
  input wire logic                        fire_osc_in,
  input wire logic                        fault_in,
  input wire logic                        mode_460_in,
  // Firing and status
  input wire logic [`IPFS_INV_SCRS-1:0]   inv_fire_out,
  input wire logic [`IPFS_COMM_SCRS-1:0]  comm_fire_out,
  input wire logic [`IPFS_PSU_SCRS-1:0]   psu_fire_out,
  input wire logic [`IPFS_PSU_SCRS-1:0]   psu_pair_fire_out,
  input wire ipfs_pkg::ipfs_step_type     step_out,
  input wire logic [`IPFS_PHASES-1:0]     phase_running_out,
  input wire logic                        fault_active_out
);
  import ipfs_pkg::*;
  logic [11:0] short_ch;
  logic [5:0]  out_mask;
  logic        strap;
  int          run_len [12];
  // ---------------------------------------------------------------
  // Helper logic
  // ---------------------------------------------------------------
  // Short channels side by side; outgoing switch of the current step
  assign short_ch = {psu_pair_fire_out, psu_fire_out, comm_fire_out};
  assign out_mask = {step_out[4], step_out[1], step_out[2], step_out[5], step_out[0], step_out[3]};
  // Strap only counts as captured during reset
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      strap <= mode_460_in;
    end
  end
  // Run length of each pulse; a counter keeps repetition counts small
  always_ff @(posedge clk_in) begin
    for (int i = 0; i < 12; i++) begin
      run_len[i] <= (reset_in || !short_ch[i]) ? 0 : run_len[i] + 1;
    end
  end
  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (reset_in);
  a_reset_idle: assert property (disable iff (1'b0)
    reset_in |=> inv_fire_out == 6'h00 && short_ch == 12'h000 && step_out == IPFS_STEP_5
      && phase_running_out == 3'h0 && !fault_active_out) else $error("reset state wrong");
  a_step_advance: assert property (comm_pulse_in |=>
    step_out == {$past(step_out[4:0]), $past(step_out[5])}) else $error("step not rotated");
  a_step_hold: assert property (!comm_pulse_in |=> $stable(step_out))
    else $error("step moved without pulse");
  a_outgoing_off: assert property (comm_pulse_in && !fault_in |=>
    (inv_fire_out & out_mask) == 6'h00) else $error("outgoing gate still on");
  a_fault_shoot: assert property (fault_in |=>
    inv_fire_out == {6{$past(fire_osc_in)}} && fault_active_out) else $error("no shoot-through");
  a_fault_stops: assert property (fault_in |=> phase_running_out == 3'h0)
    else $error("phase left running in fault");
  a_inv_chopped: assert property (inv_fire_out != 6'h00 |-> $past(fire_osc_in))
    else $error("gate not chopped");
  a_pair_strap: assert property (psu_pair_fire_out == (strap ? psu_fire_out : 3'h0))
    else $error("series pair mismatch");
  a_comm_cause: assert property ((comm_fire_out & ~$past(comm_fire_out)) != 6'h00
    |-> $past(comm_fire_in, 2)) else $error("commutation pulse without command");
  a_psu_cause: assert property ((psu_fire_out & ~$past(psu_fire_out)) != 3'h0
    |-> $past(oncoming_fire_in, 2)) else $error("supply pulse without command");
  for (genvar g = 0; g < 12; g++) begin : g_width
    a_pulse_long: assert property (short_ch[g] |-> run_len[g] < PULSE_CYCLES)
      else $error("short pulse too long");
    a_pulse_short: assert property ($fell(short_ch[g]) && !$past(reset_in) |->
      run_len[g] == PULSE_CYCLES) else $error("short pulse too short");
  end
  c_fault: cover property (fault_in ##1 fault_active_out);
  c_supply: cover property (psu_fire_out != 3'h0);
  c_stop: cover property ($fell(phase_running_out[0]));
endmodule

bind ipfs_sequencer ipfs_sequencer_chk #(.PULSE_CYCLES(PULSE_CYCLES)) u_chk (
  .clk_in(clk_in), .reset_in(reset_in), .comm_pulse_in(comm_pulse_in),
  .comm_fire_in(comm_fire_in), .oncoming_fire_in(oncoming_fire_in), .fire_osc_in(fire_osc_in),
  .fault_in(fault_in), .mode_460_in(mode_460_in), .inv_fire_out(inv_fire_out),
  .comm_fire_out(comm_fire_out), .psu_fire_out(psu_fire_out),
  .psu_pair_fire_out(psu_pair_fire_out), .step_out(step_out),
  .phase_running_out(phase_running_out), .fault_active_out(fault_active_out));

// [ipfs_scr_gate_model.sv]
// Behavioural pulse transformer drivers that count gate pulses
`timescale 1ns/10ps
`include "ipfs_defines.svh"

module ipfs_scr_gate_model (
  // Clock and reset
  input  wire logic                        clk_in,
  input  wire logic                        reset_in,
  // Short gate commands
  input  wire logic [`IPFS_COMM_SCRS-1:0]  comm_gate_in,
  input  wire logic [`IPFS_PSU_SCRS-1:0]   psu_gate_in,
  input  wire logic [`IPFS_PSU_SCRS-1:0]   pair_gate_in,
  // Pulses seen
  output logic      [15:0]                 events_out
);
  logic [11:0] prev;
  // One event per rising edge; a held gate still counts once
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      events_out <= 16'h0000;
      prev       <= 12'h000;
    end else begin
      events_out <= events_out + 16'($countones({pair_gate_in, psu_gate_in, comm_gate_in}
                    & ~prev));
      prev       <= {pair_gate_in, psu_gate_in, comm_gate_in};
    end
  end
endmodule

// [inverter_phase_firing_sequencer_tb.sv]
// Self-checking bench for the inverter phase firing sequencer
`timescale 1ns/10ps
`include "ipfs_defines.svh"

module inverter_phase_firing_sequencer_tb;
  import ipfs_pkg::*;
  localparam int PC = 4;
  logic           clk_in = 1'b0;
  logic           reset_in = 1'b1;
  logic           comm_pulse_in = 1'b0;
  logic           comm_fire_in = 1'b0;
  logic           oncoming_fire_in = 1'b0;
  logic           fire_osc_in = 1'b1;
  logic           fault_in = 1'b0;
  logic [2:0]     phase_run_in = 3'h0;
  logic           mode_460_in = 1'b0;
  logic           strap = 1'b0;
  logic [5:0]     inv_fire_out;
  logic [5:0]     comm_fire_out;
  logic [2:0]     psu_fire_out;
  logic [2:0]     psu_pair_fire_out;
  ipfs_step_type  step_out;
  logic [2:0]     phase_running_out;
  logic           fault_active_out;
  logic [15:0]    events;
  int             fails = 0;
  int             comparisons = 0;
  // 200 MHz control clock
  always #2.5 clk_in = ~clk_in;
  ipfs_sequencer #(.PULSE_CYCLES(PC)) u_dut (.clk_in(clk_in), .reset_in(reset_in),
    .comm_pulse_in(comm_pulse_in), .comm_fire_in(comm_fire_in),
    .oncoming_fire_in(oncoming_fire_in), .fire_osc_in(fire_osc_in), .fault_in(fault_in),
    .phase_run_in(phase_run_in), .mode_460_in(mode_460_in), .inv_fire_out(inv_fire_out),
    .comm_fire_out(comm_fire_out), .psu_fire_out(psu_fire_out),
    .psu_pair_fire_out(psu_pair_fire_out), .step_out(step_out),
    .phase_running_out(phase_running_out), .fault_active_out(fault_active_out));
  ipfs_scr_gate_model u_model (.clk_in(clk_in), .reset_in(reset_in),
    .comm_gate_in(comm_fire_out), .psu_gate_in(psu_fire_out),
    .pair_gate_in(psu_pair_fire_out), .events_out(events));
  // ---------------------------------------------------------------
  // Shared tasks; inputs change on the falling edge only
  // ---------------------------------------------------------------
  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    comparisons++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic idle(input int n);
    repeat (n) @(negedge clk_in);
  endtask
  task automatic wrap_up;
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // Reset held ten cycles; strap is captured meanwhile
  task automatic do_reset(input logic strap_val);
    reset_in = 1'b1;
    mode_460_in = strap_val;
    strap = strap_val;
    idle(10);
    reset_in = 1'b0;
    check("reset step", IPFS_STEP_5, step_out);
    check("reset outputs", 16'h0000, {inv_fire_out, comm_fire_out, phase_running_out,
      fault_active_out});
    $display("test reset done");
  endtask
  // One commutation interval; ev below zero skips the event count
  task automatic commutate(input logic [5:0] st, input logic [5:0] inv, input logic [2:0] psu,
                           input int ev);
    logic [15:0] ev0;
    ev0 = events;
    comm_pulse_in = 1'b1;
    idle(1);
    comm_pulse_in = 1'b0;
    check("step", st, step_out);
    idle(1);
    comm_fire_in = 1'b1;
    idle(1);
    comm_fire_in = 1'b0;
    idle(2);
    oncoming_fire_in = 1'b1;
    idle(1);
    oncoming_fire_in = 1'b0;
    idle(1);
    check("inverter gates", inv, inv_fire_out);
    check("supply pulse", psu, psu_fire_out);
    check("pair pulse", strap ? psu : 3'h0, psu_pair_fire_out);
    // Outgoing switch of the steered phase, only where it was running
    check("comm pulse", (ev >= 0) ? {10'h000, st[4], st[1], st[2], st[5], st[0], st[3]}
      : 16'h0000, comm_fire_out);
    idle(PC + 4);
    if (ev >= 0) begin
      check("pulse events", 16'(ev), events - ev0);
    end
  endtask
  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task automatic t_run_up;
    phase_run_in = 3'h7;
    commutate(IPFS_STEP_0, 6'h00, 3'h1, -1);
    commutate(IPFS_STEP_1, 6'h00, 3'h0, -1);
    commutate(IPFS_STEP_2, 6'h00, 3'h2, -1);
    commutate(IPFS_STEP_3, 6'h02, 3'h1, 3);
    commutate(IPFS_STEP_4, 6'h02, 3'h4, -1);
    commutate(IPFS_STEP_5, 6'h0a, 3'h2, 3);
    commutate(IPFS_STEP_0, 6'h09, 3'h1, 3);
    commutate(IPFS_STEP_1, 6'h29, 3'h4, 3);
    check("running", 3'h7, phase_running_out);
    fire_osc_in = 1'b0;
    idle(2);
    check("chopped gates", 6'h00, inv_fire_out);
    fire_osc_in = 1'b1;
    idle(2);
    check("restored gates", 6'h29, inv_fire_out);
    $display("test run_up done");
  endtask
  task automatic t_stop;
    phase_run_in = 3'h6;
    commutate(IPFS_STEP_2, 6'h25, 3'h2, 3);
    commutate(IPFS_STEP_3, 6'h26, 3'h1, 3);
    commutate(IPFS_STEP_4, 6'h16, 3'h4, 3);
    commutate(IPFS_STEP_5, 6'h1a, 3'h2, 3);
    commutate(IPFS_STEP_0, 6'h18, 3'h0, 1);
    check("running", 3'h6, phase_running_out);
    $display("test stop done");
  endtask
  task automatic t_fault;
    fault_in = 1'b1;
    idle(1);
    check("shoot-through", 6'h3f, inv_fire_out);
    check("fault flag", 1'b1, fault_active_out);
    fire_osc_in = 1'b0;
    comm_pulse_in = 1'b1;
    idle(1);
    comm_pulse_in = 1'b0;
    check("chopped shoot", 6'h00, inv_fire_out);
    check("step in fault", IPFS_STEP_1, step_out);
    check("all stopped", 3'h0, phase_running_out);
    fire_osc_in = 1'b1;
    fault_in = 1'b0;
    idle(2);
    check("gates after fault", 6'h00, inv_fire_out);
    $display("test fault done");
  endtask
  // Mid-run reset with the strap open: supply pulses lose their partner
  task automatic t_restart;
    do_reset(1'b0);
    phase_run_in = 3'h1;
    commutate(IPFS_STEP_0, 6'h00, 3'h1, -1);
    commutate(IPFS_STEP_1, 6'h00, 3'h0, -1);
    commutate(IPFS_STEP_2, 6'h00, 3'h0, -1);
    commutate(IPFS_STEP_3, 6'h02, 3'h1, 2);
    $display("test restart done");
  endtask
  // Whole run is a few hundred cycles
  initial begin
    #20000;
    fails++;
    $display("MISMATCH watchdog expected finish seen timeout");
    wrap_up();
  end
  initial begin
    @(negedge clk_in);
    do_reset(1'b1);
    t_run_up();
    t_stop();
    t_fault();
    t_restart();
    wrap_up();
  end
endmodule
